// File: design/lss_pkg.sv
package lss_pkg;
  localparam int ADDR_W = 12;
  localparam int CLK_PERIOD_NS = 5;
  // timing figures in ns, slowest grade
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_ADDR_HOLD_NS = 50;
  localparam int T_STROBE_LOW_NS = 350;
  localparam int T_STROBE_HIGH_NS = 150;
  localparam int T_ACCESS_NS = 350;
  localparam int T_WR_PULSE_NS = 100;
  localparam int T_WR_SETUP_NS = 250;
  localparam int T_DATA_SETUP_NS = 30;
  localparam int T_DATA_HOLD_NS = 100;
  localparam int T_CYCLE_NS = 500;
  // least times round up
  localparam int C_ADDR_SETUP = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_ADDR_HOLD = (T_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_ACCESS = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_STROBE_LOW_RAW = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_STROBE_HIGH_RAW = (T_STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_WR_PULSE = (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_WR_SETUP = (T_WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_DATA_SETUP = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_DATA_HOLD = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_CYCLE = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // high phase stretched so that low plus high meets the full cycle time
  localparam int C_STROBE_HIGH = (C_CYCLE - C_STROBE_LOW_RAW > C_STROBE_HIGH_RAW) ?
                                 C_CYCLE - C_STROBE_LOW_RAW : C_STROBE_HIGH_RAW;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RMW = 2'h2;
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_IDLE    = 3'b001,
    ST_SETUP   = 3'b010,
    ST_ACCESS  = 3'b011,
    ST_WRITE   = 3'b100,
    ST_RECOVER = 3'b101
  } lss_state_type;
endpackage

// File: design/lss_host.sv
`timescale 1ns/1ps
module lss_host (
  // clock and reset
  input  wire logic                      CLK_I,
  input  wire logic                      RESET_I,
  // user request side
  input  wire logic                      REQ_VALID_I,
  input  wire logic [1:0]                REQ_OP_I,
  input  wire logic [lss_pkg::ADDR_W-1:0] REQ_ADDR_I,
  input  wire logic                      REQ_DATA_I,
  input  wire logic                      REQ_INVERT_I,
  input  wire logic                      BACKUP_I,
  output logic                           REQ_READY_O,
  output logic                           RSP_VALID_O,
  output logic                           RSP_DATA_O,
  // memory pins
  output logic                           MEM_STROBE_N_O,
  output logic                           MEM_WRITE_N_O,
  output logic [lss_pkg::ADDR_W-1:0]     MEM_ADDR_O,
  output logic                           MEM_DIN_O,
  input  wire logic                      MEM_DOUT_I,
  input  wire logic                      MEM_DOUT_OE_I
);
  lss_pkg::lss_state_type state_ff, nxt_state;
  logic [lss_pkg::CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [1:0]                 op_ff, nxt_op;
  logic                       inv_ff, nxt_inv;
  logic                       strobe_n_ff, nxt_strobe_n;
  logic                       write_n_ff, nxt_write_n;
  logic [lss_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic                       din_ff, nxt_din;
  logic                       ready_ff, nxt_ready;
  logic                       rsp_valid_ff, nxt_rsp_valid;
  logic                       rsp_data_ff, nxt_rsp_data;
  // outside pins: backup flag, memory data bit, memory drive enable
  localparam int PIN_N = 3;
  logic [PIN_N-1:0]           pin_raw;
  wire logic [PIN_N-1:0]      pin_sync;
  logic                       backup_sync;
  logic                       dout_sync;
  logic                       oe_sync;

  function automatic logic [lss_pkg::CNT_W-1:0] cyc(input int n);
    cyc = lss_pkg::CNT_W'(n);
  endfunction

  // phase counter has reached n cycles
  function automatic logic reached(input logic [lss_pkg::CNT_W-1:0] c, input int n);
    reached = (c >= cyc(n));
  endfunction

  // every cycle but early write keeps the write strobe high at the falling edge
  function automatic logic op_reads(input logic [1:0] op);
    op_reads = (op != lss_pkg::OP_WRITE);
  endfunction

  assign pin_raw = {MEM_DOUT_OE_I, MEM_DOUT_I, BACKUP_I};

  // two flops per pin; only the second is read, the first may be metastable
  for (genvar g = 0; g < PIN_N; g++) begin : g_sync
    logic s1_ff;
    logic s2_ff;
    always_ff @(posedge CLK_I) begin
      s1_ff <= pin_raw[g];
      s2_ff <= s1_ff;
    end
    assign pin_sync[g] = s2_ff;
  end

  assign backup_sync = pin_sync[0];
  assign dout_sync   = pin_sync[1];
  assign oe_sync     = pin_sync[2];

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff + cyc(1);
    nxt_op        = op_ff;
    nxt_inv       = inv_ff;
    nxt_strobe_n  = strobe_n_ff;
    nxt_write_n   = write_n_ff;
    nxt_addr      = addr_ff;
    nxt_din       = din_ff;
    nxt_ready     = 1'b0;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data  = rsp_data_ff;
    unique case (state_ff)
      lss_pkg::ST_POWERUP: begin
        // strobe held high one strobe-high interval after power good
        nxt_strobe_n = 1'b1;
        if (backup_sync) begin
          nxt_cnt = lss_pkg::CNT_RESET;
        end else if (reached(cnt_ff, lss_pkg::C_STROBE_HIGH)) begin
          nxt_state = lss_pkg::ST_IDLE;
          nxt_ready = 1'b1;
        end
      end

      lss_pkg::ST_IDLE: begin
        nxt_strobe_n = 1'b1;
        nxt_ready    = ~backup_sync;
        if (backup_sync) begin
          // no cycle may start in backup; wait again after recovery
          nxt_state = lss_pkg::ST_POWERUP;
          nxt_cnt   = lss_pkg::CNT_RESET;
        end else if (REQ_VALID_I && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_op    = REQ_OP_I;
          nxt_inv   = REQ_INVERT_I;
          nxt_addr  = REQ_ADDR_I;
          nxt_din   = REQ_DATA_I;
          // write strobe level set ahead of the edge picks the cycle type
          nxt_write_n = op_reads(REQ_OP_I);
          nxt_cnt   = lss_pkg::CNT_RESET;
          nxt_state = lss_pkg::ST_SETUP;
        end
      end

      lss_pkg::ST_SETUP: begin
        // address, data and write level settle before the falling edge
        if (reached(cnt_ff, lss_pkg::C_ADDR_SETUP - 1)) begin
          nxt_strobe_n = 1'b0;
          nxt_cnt      = lss_pkg::CNT_RESET;
          nxt_state    = lss_pkg::ST_ACCESS;
        end
      end

      lss_pkg::ST_ACCESS: begin
        // address and data held past hold time after the edge
        // strobe low must last the strobe low time plus two sync flops
        // before the data bit is sampled; write strobe keeps the level set in idle
        // reads also wait for the output drive; a memory that never drives stalls here
        if (reached(cnt_ff, lss_pkg::C_STROBE_LOW_RAW + 2) && (!op_reads(op_ff) || oe_sync)) begin
          if (op_ff == lss_pkg::OP_RMW) begin
            nxt_rsp_data = dout_sync;
            nxt_din      = dout_sync ^ inv_ff;
            nxt_cnt      = lss_pkg::CNT_RESET;
            nxt_state    = lss_pkg::ST_WRITE;
          end else begin
            if (op_ff == lss_pkg::OP_READ) begin
              nxt_rsp_data = dout_sync;
            end
            // read sampled, strobe rises, output released
            nxt_strobe_n = 1'b1;
            nxt_cnt      = lss_pkg::CNT_RESET;
            nxt_state    = lss_pkg::ST_RECOVER;
          end
        end
      end

      lss_pkg::ST_WRITE: begin
        // modify phase: write strobe low, data setup before it
        if (cnt_ff == cyc(lss_pkg::C_DATA_SETUP)) begin
          nxt_write_n = 1'b0;
        end
        // strobe rises write setup time after the write strobe falls; completes the write
        if (reached(cnt_ff, lss_pkg::C_DATA_SETUP + lss_pkg::C_WR_SETUP)) begin
          nxt_strobe_n = 1'b1;
          nxt_cnt      = lss_pkg::CNT_RESET;
          nxt_state    = lss_pkg::ST_RECOVER;
        end
      end

      lss_pkg::ST_RECOVER: begin
        // strobe high interval before the next cycle
        nxt_write_n = 1'b1;
        if (reached(cnt_ff, lss_pkg::C_STROBE_HIGH - 1)) begin
          nxt_rsp_valid = 1'b1;
          nxt_ready     = ~backup_sync;
          nxt_state     = lss_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state    = lss_pkg::ST_POWERUP;
        nxt_strobe_n = 1'b1;
        nxt_cnt      = lss_pkg::CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_ff     <= lss_pkg::ST_POWERUP;
      cnt_ff       <= lss_pkg::CNT_RESET;
      op_ff        <= lss_pkg::OP_READ;
      inv_ff       <= 1'b0;
      strobe_n_ff  <= 1'b1;
      write_n_ff   <= 1'b1;
      addr_ff      <= '0;
      din_ff       <= 1'b0;
      ready_ff     <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      op_ff        <= nxt_op;
      inv_ff       <= nxt_inv;
      strobe_n_ff  <= nxt_strobe_n;
      write_n_ff   <= nxt_write_n;
      addr_ff      <= nxt_addr;
      din_ff       <= nxt_din;
      ready_ff     <= nxt_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff  <= nxt_rsp_data;
    end
  end

  assign REQ_READY_O    = ready_ff;
  assign RSP_VALID_O    = rsp_valid_ff;
  assign RSP_DATA_O     = rsp_data_ff;
  assign MEM_STROBE_N_O = strobe_n_ff;
  assign MEM_WRITE_N_O  = write_n_ff;
  assign MEM_ADDR_O     = addr_ff;
  assign MEM_DIN_O      = din_ff;
endmodule

// File: bench/lss_host_monitor.sv
`timescale 1ns/1ps
module lss_host_monitor (
  // watched ports
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        BACKUP_I,
  input wire logic        REQ_READY_O,
  input wire logic        RSP_VALID_O,
  input wire logic        MEM_STROBE_N_O,
  input wire logic        MEM_WRITE_N_O,
  input wire logic [11:0] MEM_ADDR_O,
  input wire logic        MEM_DIN_O
);
  logic [7:0] hi_cnt_ff;
  logic [7:0] nxt_hi_cnt;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // saturates so a long idle never wraps back below the limit
  always_comb nxt_hi_cnt = !MEM_STROBE_N_O ? 8'h00 : (hi_cnt_ff == 8'hFF) ? hi_cnt_ff : hi_cnt_ff + 8'h01;
  always_ff @(posedge CLK_I) hi_cnt_ff <= RESET_I ? 8'h00 : nxt_hi_cnt;
  sequence s_fall; $fell(MEM_STROBE_N_O); endsequence
  sequence s_read; $fell(MEM_STROBE_N_O) && MEM_WRITE_N_O; endsequence
  sequence s_early; $fell(MEM_STROBE_N_O) && !MEM_WRITE_N_O; endsequence
  AST_READ_WR_HIGH: assert property (s_read |-> MEM_WRITE_N_O [*8])
    else $error("write strobe low too soon in read");
  AST_LOW_SPAN: assert property (s_fall |-> !MEM_STROBE_N_O [*8])
    else $error("cycle strobe low too short");
  AST_RSP_AFTER: assert property ($rose(MEM_STROBE_N_O) |-> ##[20:40] RSP_VALID_O)
    else $error("no response after cycle end");
  AST_EW_HOLD: assert property (s_early |-> (!MEM_WRITE_N_O && $stable(MEM_DIN_O)) [*8])
    else $error("early write data or strobe moved");
  AST_ADDR_HOLD: assert property (s_fall |-> $stable(MEM_ADDR_O) [*8])
    else $error("address moved after cycle start");
  AST_BACKUP: assert property ((BACKUP_I && MEM_STROBE_N_O) [*8] |=> MEM_STROBE_N_O)
    else $error("cycle started in backup");
  AST_HIGH_GAP: assert property (s_fall |-> hi_cnt_ff >= 8'(lss_pkg::C_STROBE_HIGH))
    else $error("strobe high interval too short");
  AST_BUSY: assert property (!MEM_STROBE_N_O |-> !REQ_READY_O && !RSP_VALID_O)
    else $error("ready or response during cycle");
endmodule
bind lss_host lss_host_monitor lss_host_monitor_i (.CLK_I, .RESET_I, .BACKUP_I, .REQ_READY_O, .RSP_VALID_O,
  .MEM_STROBE_N_O, .MEM_WRITE_N_O, .MEM_ADDR_O, .MEM_DIN_O);

// File: bench/lss_sram_model.sv
`timescale 1ns/1ps
module lss_sram_model #(
  parameter int T_ON_NS  = 100,
  parameter int T_VAL_NS = 350
) (
  // memory pins
  input  wire logic        strobe_n_i,
  input  wire logic        write_n_i,
  input  wire logic [11:0] addr_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o
);
  logic        mem [0:4095];
  logic [11:0] addr_q;
  logic        din_q;
  logic        wr_q;
  initial begin
    dout_o = 1'b0;
    dout_oe_o = 1'b0;
  end
  always @(negedge strobe_n_i) begin
    addr_q = addr_i;
    din_q = din_i;
    wr_q = !write_n_i;
    // wrong bit until valid, so an early sample is caught
    dout_o = ~mem[addr_i];
    if (write_n_i) begin
      dout_oe_o <= #(T_ON_NS) 1'b1;
      dout_o <= #(T_VAL_NS) mem[addr_i];
    end
  end
  always @(negedge write_n_i) begin
    if (!strobe_n_i && !wr_q) begin
      wr_q = 1'b1;
      din_q = din_i;
    end
  end
  always @(posedge strobe_n_i) begin
    if (wr_q) mem[addr_q] = din_q;
    wr_q = 1'b0;
    dout_oe_o = 1'b0;
    dout_o = ~dout_o;
  end
endmodule

// File: bench/lss_host_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module lss_host_tb;
  logic clk = 0, rst = 1, vld = 0, din = 0, inv = 0, bkp = 0;
  logic [1:0] op = 0;
  logic [11:0] adr = 0, maddr;
  logic rdy, rsp_v, rsp_d, stb_n, wr_n, mdin, dout, oe;
  int err_total = 0, checks = 0, oe_cnt = 0, fall_cnt = 0;
  always #2.5 clk = ~clk;
  always @(posedge oe) oe_cnt++;
  always @(negedge stb_n) fall_cnt++;
  lss_host lss_host_i (.CLK_I(clk), .RESET_I(rst), .REQ_VALID_I(vld), .REQ_OP_I(op), .REQ_ADDR_I(adr),
    .REQ_DATA_I(din), .REQ_INVERT_I(inv), .BACKUP_I(bkp), .REQ_READY_O(rdy), .RSP_VALID_O(rsp_v),
    .RSP_DATA_O(rsp_d), .MEM_STROBE_N_O(stb_n), .MEM_WRITE_N_O(wr_n), .MEM_ADDR_O(maddr),
    .MEM_DIN_O(mdin), .MEM_DOUT_I(dout), .MEM_DOUT_OE_I(oe));
  lss_sram_model lss_sram_model_i (.strobe_n_i(stb_n), .write_n_i(wr_n), .addr_i(maddr), .din_i(mdin),
    .dout_o(dout), .dout_oe_o(oe));
  task automatic wait_rsp();
    int n;
    n = 0;
    while (rsp_v !== 1'b1 && n < 400) begin @(negedge clk); n++; end
    `CHK("rsp_valid", 1'b1, rsp_v)
  endtask
  task automatic req(input logic [1:0] o, input logic [11:0] a, input logic d, input logic iv);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin @(negedge clk); n++; end
    op = o; adr = a; din = d; inv = iv; vld = 1;
    @(negedge clk);
    vld = 0;
    wait_rsp();
  endtask
  task automatic t_write_read();
    logic [11:0] a [3] = '{12'h000, 12'hFFF, 12'h5A5};
    int o;
    for (int i = 0; i < 3; i++) begin
      o = oe_cnt;
      req(lss_pkg::OP_WRITE, a[i], ~i[0], 1'b0);
      `CHK("ew_oe", o, oe_cnt)
    end
    for (int i = 0; i < 3; i++) begin
      o = oe_cnt;
      req(lss_pkg::OP_READ, a[i], 1'b0, 1'b0);
      `CHK("rd_data", ~i[0], rsp_d)
      `CHK("rd_oe", o + 1, oe_cnt)
    end
  endtask
  task automatic t_rmw();
    logic e;
    int o;
    e = 1'b1;
    for (int i = 1; i >= 0; i--) begin
      o = oe_cnt;
      req(lss_pkg::OP_RMW, 12'h5A5, 1'b0, i[0]);
      `CHK("rmw_oe", o + 1, oe_cnt)
      `CHK("rmw_old", e, rsp_d)
      e = e ^ i[0];
      req(lss_pkg::OP_READ, 12'h5A5, 1'b0, 1'b0);
      `CHK("rmw_new", e, rsp_d)
    end
  endtask
  task automatic t_spare_op();
    int o;
    o = oe_cnt;
    req(2'h3, 12'h000, 1'b0, 1'b0);
    `CHK("op3_keep", 1'b0, rsp_d)
    `CHK("op3_oe", o + 1, oe_cnt)
    req(lss_pkg::OP_READ, 12'h000, 1'b0, 1'b0);
    `CHK("op3_array", 1'b1, rsp_d)
  endtask
  task automatic t_backup();
    int f, n;
    bkp = 1;
    repeat (10) @(negedge clk);
    f = fall_cnt;
    op = lss_pkg::OP_READ; adr = 12'hFFF; vld = 1;
    repeat (100) @(negedge clk);
    `CHK("bk_cycles", f, fall_cnt)
    `CHK("bk_ready", 1'b0, rdy)
    bkp = 0;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin @(negedge clk); n++; end
    @(negedge clk);
    vld = 0;
    wait_rsp();
    `CHK("bk_data", 1'b0, rsp_d)
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(20000 * 5);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    t_write_read();
    t_rmw();
    t_spare_op();
    t_backup();
    end_sim();
  end
endmodule
